// >>> verification/opf_framer_tb.sv
// Self-checking bench for the management packet framer
module opf_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] PORT = 12'h123;
  logic        clk, rst_n, regWrite, regRead, rxValid, rxSop, rxCrcOk;
  logic        txValid, txLast, cmdValid, cmdPrio, lastPrio;
  logic [3:0]  regAddr;
  logic [7:0]  rxData, txData;
  logic [4:0]  cmdCode, lastCode;
  logic [31:0] regWdata, regRdata, crcIn, cmdMsgId, lastMid, rdv;
  logic [15:0] lfsr = 16'h431d;
  int          mismatches, totalChecks, cmdSeen, syncCnt, almCnt, uplCnt;

  opf_framer opf_framer_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxValid(rxValid), .rxSop(rxSop),
    .rxData(rxData), .rxCrcOk(rxCrcOk), .crcIn(crcIn), .txValid(txValid), .txData(txData),
    .txLast(txLast), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdMsgId(cmdMsgId), .cmdPrio(cmdPrio));
  opf_olt_model opf_olt_model_i (.clk(clk), .rxValid(rxValid), .rxSop(rxSop), .rxData(rxData),
    .rxCrcOk(rxCrcOk), .crcIn(crcIn), .txValid(txValid), .txData(txData), .txLast(txLast));

  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Accepted commands are single-cycle pulses, so count them here
  always @(posedge clk) begin
    if (cmdValid === 1'b1) begin
      cmdSeen++;
      lastCode = cmdCode;
      lastMid  = cmdMsgId;
      lastPrio = cmdPrio;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] nextRand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : nextRand

  function automatic logic [423:0] mkPkt(logic [11:0] port, logic [2:0] pti, logic [15:0] tci,
                                         logic [7:0] mt, logic [7:0] dev, logic [31:0] mid);
    return {opf_pkg::TX_PLI, port, pti, 13'h0000, tci, mt, dev, mid, 256'h0,
            opf_pkg::TRL_CPI, opf_pkg::TRL_LEN, crcIn};
  endfunction : mkPkt

  task automatic testDone();
    $display("Checks %0d, mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : testDone

  task automatic check(input logic ok, input string what);
    totalChecks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error %0t: %s", $time, what);
    end
  endtask : check

  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : regWr

  // Read data stands only in the cycle after the strobe
  task automatic regRd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask : regRd

  // Bounded wait for a whole 53-byte reply, then byte-exact compare
  task automatic cmpTx(input logic [423:0] exp);
    logic [423:0] got;
    int n;
    for (n = 0; n < 200 && opf_olt_model_i.txQ.size() < 53; n++) @(posedge clk);
    if (n == 200) begin
      mismatches++;
      testDone();
    end
    for (int i = 0; i < 53; i++) got[423-8*i -: 8] = opf_olt_model_i.txQ[i];
    check(got === exp && opf_olt_model_i.txQ.size() == 53, "reply bytes");
    check(opf_olt_model_i.lastAt == 53, "last byte mark");
    repeat (3) @(posedge clk);
  endtask : cmpTx

  task automatic doPkt(input logic [15:0] tci, input logic [7:0] mt, input logic [31:0] mid,
                       input logic [11:0] port, input logic [2:0] pti, input logic [7:0] dev,
                       input logic crcOk, input bit acc);
    int c0;
    c0 = cmdSeen;
    opf_olt_model_i.txQ.delete();
    opf_olt_model_i.send(mkPkt(port, pti, tci, mt, dev, mid), crcOk);
    repeat (4) @(posedge clk);
    check((cmdSeen - c0) == (acc ? 1 : 0), "acceptance");
    if (acc) begin
      check(lastCode === mt[4:0] && lastMid === mid && lastPrio === tci[15], "command fields");
      if (mt[4:0] == 5'd15) syncCnt = 0;
      else if (mt[4:0] inside {4, 6, 8, 19, 21, 22, 23}) syncCnt++;
      if (mt[4:0] == 5'd11) almCnt = 0;
      if (mt[4:0] == 5'd12) almCnt++;
      if (mt[4:0] == 5'd13) uplCnt = 0;
      if (mt[4:0] == 5'd14) uplCnt++;
    end
    if (acc && mt[6]) cmpTx(mkPkt(PORT, 3'h1, tci, {3'b001, mt[4:0]}, opf_pkg::DEV_ID, mid));
    else begin
      repeat (60) @(posedge clk);
      check(opf_olt_model_i.txQ.size() == 0, "unexpected reply");
    end
    if (acc) begin
      regRd(opf_pkg::A_TCI, rdv);
      check(rdv === {16'h0, tci}, "latched correlation");
    end
    regRd(opf_pkg::A_SYNC, rdv);
    check(rdv === 32'(syncCnt), "sync counter");
    regRd(opf_pkg::A_ALMSQ, rdv);
    check(rdv === 32'(almCnt), "alarm sequence");
    regRd(opf_pkg::A_UPLSQ, rdv);
    check(rdv === 32'(uplCnt), "upload sequence");
  endtask : doPkt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] mid;
    logic [4:0]  ev[3];
    logic [11:0] bPort[6];
    logic [2:0]  bPti[6];
    logic [7:0]  bMt[6];
    logic [7:0]  bDev[6];
    logic        bCrc[6];
    int          bBit[6];
    rst_n    = 1'b0;
    regAddr  = 4'h0;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead  = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    regRd(opf_pkg::A_CTRL, rdv);
    check(rdv === 32'h0, "control reset value");
    regRd(4'hf, rdv);
    check(rdv === 32'h0, "unmapped read");
    // Disabled block ignores a good request
    doPkt(16'h8001, 8'h49, 32'h0001_0002, 12'h000, 3'h0, opf_pkg::DEV_ID, 1'b1, 0);
    regWr(opf_pkg::A_CTRL, {19'h0, 1'b1, PORT});
    regRd(opf_pkg::A_CTRL, rdv);
    check(rdv === {19'h0, 1'b1, PORT}, "control readback");
    // Every type code with a response requested; fresh correlation each time
    for (int c = 0; c < 32; c++) begin
      mid = {nextRand(), nextRand()};
      doPkt(nextRand(), {3'b010, 5'(c)}, mid, PORT, 3'(c % 2), opf_pkg::DEV_ID, 1'b1,
            c >= 4 && c <= 28 && !(c inside {5, 7, 10, 16, 17, 27}));
    end
    // Unacknowledged download section: accepted, silent
    doPkt(nextRand(), 8'h14, 32'h0007_0001, PORT, 3'h0, opf_pkg::DEV_ID, 1'b1, 1);
    // Malformed requests, each with its sticky error bit
    bPort = '{PORT ^ 12'h001, PORT, PORT, PORT, PORT, PORT};
    bPti  = '{3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
    bMt   = '{8'h49, 8'h49, 8'hc9, 8'h49, 8'h49, 8'h69};
    bDev  = '{opf_pkg::DEV_ID, opf_pkg::DEV_ID, opf_pkg::DEV_ID, ~opf_pkg::DEV_ID,
              opf_pkg::DEV_ID, opf_pkg::DEV_ID};
    bCrc  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    bBit  = '{0, 1, 2, 3, 6, 7};
    regWr(opf_pkg::A_ERR, 32'h1ff);
    for (int i = 0; i < 6; i++) begin
      doPkt(nextRand(), bMt[i], 32'h0002_0003, bPort[i], bPti[i], bDev[i], bCrc[i], 0);
      regRd(opf_pkg::A_ERR, rdv);
      check(rdv === (32'h1 << bBit[i]), "error flag");
      regWr(opf_pkg::A_ERR, 32'h1ff);
    end
    regRd(opf_pkg::A_ERR, rdv);
    check(rdv === 32'h0, "error clear");
    // Autonomous notifications: zero correlation, no flags
    mid = {nextRand(), nextRand()};
    regWr(opf_pkg::A_EVTID, mid);
    ev = '{5'd16, 5'd17, 5'd27};
    for (int i = 0; i < 3; i++) begin
      opf_olt_model_i.txQ.delete();
      regWr(opf_pkg::A_EVENT, {27'h0, ev[i]});
      cmpTx(mkPkt(PORT, 3'h1, opf_pkg::EVT_TCI, {3'b000, ev[i]}, opf_pkg::DEV_ID, mid));
    end
    testDone();
  end
endmodule : opf_framer_tb

// >>> verification/opf_olt_model.sv
// Line terminal management controller model: sends requests, collects replies
module opf_olt_model (
  input  wire logic        clk,
  output logic             rxValid,
  output logic             rxSop,
  output logic      [7:0]  rxData,
  output logic             rxCrcOk,
  output logic      [31:0] crcIn,
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  input  wire logic        txLast
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txQ[$];
  int         lastAt;

  // Quiet lines at time zero; fixed trailer word
  initial begin
    rxValid = 1'b0;
    rxSop   = 1'b0;
    rxData  = 8'h00;
    rxCrcOk = 1'b0;
    crcIn   = 32'h5a3c_9e01;
  end

  // Consumer never stalls, so every valid byte is kept
  always @(posedge clk) begin
    if (txValid === 1'b1) begin
      txQ.push_back(txData);
      if (txLast === 1'b1) lastAt = txQ.size();
    end
  end

  // One whole packet, byte 0 marked as start
  task automatic send(input logic [423:0] pkt, input logic crcOk);
    for (int i = 0; i < 53; i++) begin
      @(posedge clk);
      rxValid <= 1'b1;
      rxSop   <= (i == 0);
      rxData  <= pkt[423-8*i -: 8];
      rxCrcOk <= crcOk;
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxSop   <= 1'b0;
    rxData  <= ~rxData; // Released line shows no stale byte
    rxCrcOk <= 1'b0;
  endtask : send
endmodule : opf_olt_model

// >>> verilog/opf_framer.sv
// Management packet framer: parses requests, builds responses and events
module opf_framer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        rxValid,
  input  wire logic        rxSop,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxCrcOk,
  input  wire logic [31:0] crcIn,
  output logic             txValid,
  output logic      [7:0]  txData,
  output logic             txLast,
  output logic             cmdValid,
  output logic      [4:0]  cmdCode,
  output logic      [31:0] cmdMsgId,
  output logic             cmdPrio
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    opf_pkg::opf_rx_t rxSt;
    logic [5:0]       rxCnt;
    logic [103:0]     hdr;
    opf_pkg::opf_tx_t txSt;
    logic [5:0]       txCnt;
    logic [103:0]     txHdr;
    logic [63:0]      txTrl;
    logic             txEvt;
    logic [5:0]       txPos;
    logic             txValid;
    logic [7:0]       txData;
    logic             txLast;
    logic [11:0]      portId;
    logic             enable;
    logic [31:0]      evtId;
    logic [8:0]       err;
    logic [7:0]       sync;
    logic [15:0]      almSeq;
    logic [15:0]      uplSeq;
    logic [4:0]       lastCode;
    logic             lastPrio;
    logic [15:0]      lastTci;
    logic [31:0]      rdata;
    logic             cmdValid;
    logic [4:0]       cmdCode;
    logic [31:0]      cmdMsgId;
    logic             cmdPrio;
  } opf_state_t;

  opf_state_t r;
  opf_state_t next_r;

  // ----------------------------------------------------------------
  // Request checks on the final byte
  // ----------------------------------------------------------------
  logic        endPkt;
  logic [7:0]  mt;
  logic [4:0]  code;
  logic [15:0] rxTci;
  logic        portOk, ptiOk, dbOk, devOk, akBad;
  logic        reserved, deprec, notify, good, incSync;
  logic        respond, rspStart, evtReq, evtStart;
  logic [8:0]  errSet;
  logic [39:0] gemHdr;

  assign endPkt   = r.rxSt == opf_pkg::RX_BODY && rxValid && !rxSop && r.rxCnt == opf_pkg::LAST_IDX;
  assign mt       = r.hdr[opf_pkg::MT_MSB:opf_pkg::MT_LSB];
  assign code     = mt[4:0];
  assign rxTci    = r.hdr[opf_pkg::TCI_MSB:opf_pkg::TCI_LSB];
  assign portOk   = r.hdr[opf_pkg::PORT_MSB:opf_pkg::PORT_LSB] == r.portId;
  assign ptiOk    = r.hdr[opf_pkg::PTI_MSB:opf_pkg::PTI_LSB] <= opf_pkg::PTI_MAX;
  assign dbOk     = !mt[opf_pkg::MT_DB];
  assign devOk    = r.hdr[opf_pkg::DEV_MSB:opf_pkg::DEV_LSB] == opf_pkg::DEV_ID;
  assign akBad    = mt[opf_pkg::MT_AK];
  assign reserved = code < opf_pkg::TC_MIN || code > opf_pkg::TC_MAX;
  assign deprec   = code inside {opf_pkg::TC_CCONN, opf_pkg::TC_DCONN, opf_pkg::TC_GCONN};
  // Notifications only flow outward; received ones are refused
  assign notify   = code inside {opf_pkg::TC_ALARM, opf_pkg::TC_AVC, opf_pkg::TC_TESTRS};
  // Everything else in range is accepted, gets included
  assign good     = endPkt && rxCrcOk && portOk && ptiOk && dbOk && devOk && !akBad
                    && !reserved && !deprec && !notify && r.enable;
  assign incSync  = code inside {opf_pkg::TC_CREATE, opf_pkg::TC_DELETE, opf_pkg::TC_SET,
                                 opf_pkg::TC_SWSTRT, opf_pkg::TC_SWEND, opf_pkg::TC_SWACT,
                                 opf_pkg::TC_SWCOMM};
  // Answer only when asked; unacked download sections stay silent
  assign respond  = good && mt[opf_pkg::MT_AR];
  assign rspStart = respond && r.txSt == opf_pkg::TX_IDLE;
  assign evtReq   = regWrite && regAddr == opf_pkg::A_EVENT
                    && regWdata[4:0] inside {opf_pkg::TC_ALARM, opf_pkg::TC_AVC, opf_pkg::TC_TESTRS};
  // A response has the channel first; a clashing event is dropped
  assign evtStart = evtReq && r.txSt == opf_pkg::TX_IDLE && !respond;
  assign gemHdr   = {opf_pkg::TX_PLI, r.portId, opf_pkg::TX_PTI, opf_pkg::TX_HEC};
  // Either source can lose the channel: a busy response or a clashing event
  assign errSet   = {(respond && !rspStart) || (evtReq && !evtStart),
                     endPkt && akBad, endPkt && !rxCrcOk, endPkt && (deprec || notify),
                     endPkt && reserved, endPkt && !devOk, endPkt && !dbOk,
                     endPkt && !ptiOk, endPkt && !portOk};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.txValid  = 1'b0;
    next_r.txLast   = 1'b0;
    next_r.txData   = 8'h00;
    next_r.cmdValid = 1'b0;
    next_r.rdata    = 32'h0000_0000;

    // Receive: header bytes shift in, body and trailer are counted
    if (rxValid && rxSop) begin
      next_r.rxSt  = opf_pkg::RX_HDR;
      next_r.rxCnt = 6'h01;
      next_r.hdr   = {r.hdr[95:0], rxData};
    end else if (rxValid) begin
      unique case (r.rxSt)
        opf_pkg::RX_IDLE: ;
        opf_pkg::RX_HDR: begin
          next_r.hdr   = {r.hdr[95:0], rxData};
          next_r.rxCnt = r.rxCnt + 6'h01;
          if (r.rxCnt == opf_pkg::HDR_LAST) next_r.rxSt = opf_pkg::RX_BODY;
        end
        opf_pkg::RX_BODY: begin
          next_r.rxCnt = r.rxCnt + 6'h01;
          if (r.rxCnt == opf_pkg::LAST_IDX) next_r.rxSt = opf_pkg::RX_IDLE;
        end
        default: next_r.rxSt = opf_pkg::RX_IDLE;
      endcase
    end

    // Accepted request: hand to the core and update sequence counters
    if (good) begin
      next_r.cmdValid = 1'b1;
      next_r.cmdCode  = code;
      next_r.cmdMsgId = r.hdr[31:0];
      next_r.cmdPrio  = rxTci[15];
      next_r.lastCode = code;
      next_r.lastPrio = rxTci[15];
      next_r.lastTci  = rxTci;
      if (code == opf_pkg::TC_MIBRST) next_r.sync = 8'h00;
      else if (incSync) next_r.sync = r.sync + 8'h01;
      if (code == opf_pkg::TC_ALMALL) next_r.almSeq = 16'h0000;
      if (code == opf_pkg::TC_ALMNXT) next_r.almSeq = r.almSeq + 16'h0001;
      if (code == opf_pkg::TC_UPLOAD) next_r.uplSeq = 16'h0000;
      if (code == opf_pkg::TC_UPLNXT) next_r.uplSeq = r.uplSeq + 16'h0001;
    end

    // Transmit start: response mirrors the request header
    if (rspStart) begin
      next_r.txSt  = opf_pkg::TX_SEND;
      next_r.txCnt = 6'h00;
      next_r.txEvt = 1'b0;
      next_r.txHdr = {gemHdr, rxTci, 3'b001, code,
                      opf_pkg::DEV_ID, r.hdr[31:0]};
      next_r.txTrl = {opf_pkg::TRL_CPI, opf_pkg::TRL_LEN, crcIn};
    end else if (evtStart) begin
      next_r.txSt  = opf_pkg::TX_SEND;
      next_r.txCnt = 6'h00;
      next_r.txEvt = 1'b1;
      next_r.txHdr = {gemHdr, opf_pkg::EVT_TCI, 3'b000, regWdata[4:0],
                      opf_pkg::DEV_ID, r.evtId};
      next_r.txTrl = {opf_pkg::TRL_CPI, opf_pkg::TRL_LEN, crcIn};
    end

    // Transmit: header, zero contents, then trailer, one byte a cycle
    if (r.txSt == opf_pkg::TX_SEND) begin
      next_r.txValid = 1'b1;
      next_r.txPos   = r.txCnt;
      next_r.txLast  = r.txCnt == opf_pkg::LAST_IDX;
      next_r.txCnt   = r.txCnt + 6'h01;
      if (r.txCnt < opf_pkg::HDR_LEN) begin
        next_r.txData = r.txHdr[103:96];
        next_r.txHdr  = {r.txHdr[95:0], 8'h00};
      end else if (r.txCnt >= opf_pkg::TRL_IDX) begin
        next_r.txData = r.txTrl[63:56];
        next_r.txTrl  = {r.txTrl[55:0], 8'h00};
      end
      if (r.txCnt == opf_pkg::LAST_IDX) next_r.txSt = opf_pkg::TX_IDLE;
    end

    // Register writes; error bits are write-one-to-clear, set wins
    next_r.err = r.err | errSet;
    if (regWrite) begin
      unique case (regAddr)
        opf_pkg::A_CTRL: begin
          next_r.portId = regWdata[11:0];
          next_r.enable = regWdata[opf_pkg::CTRL_EN];
        end
        opf_pkg::A_ERR:   next_r.err   = (r.err & ~regWdata[opf_pkg::ERR_W-1:0]) | errSet;
        opf_pkg::A_EVTID: next_r.evtId = regWdata;
        default: ;
      endcase
    end

    // Register reads, data valid the following cycle only
    if (regRead) begin
      unique case (regAddr)
        opf_pkg::A_CTRL:  next_r.rdata = {19'h0, r.enable, r.portId};
        opf_pkg::A_STAT:  next_r.rdata = {24'h0, r.txSt == opf_pkg::TX_SEND, r.rxSt != opf_pkg::RX_IDLE,
                                          r.lastPrio, r.lastCode};
        opf_pkg::A_ERR:   next_r.rdata = {23'h0, r.err};
        opf_pkg::A_SYNC:  next_r.rdata = {24'h0, r.sync};
        opf_pkg::A_ALMSQ: next_r.rdata = {16'h0, r.almSeq};
        opf_pkg::A_UPLSQ: next_r.rdata = {16'h0, r.uplSeq};
        opf_pkg::A_EVTID: next_r.rdata = r.evtId;
        opf_pkg::A_TCI:   next_r.rdata = {16'h0, r.lastTci};
        default:          next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) r <= '0;
    else        r <= next_r;
  end

  assign regRdata = r.rdata;
  assign txValid  = r.txValid;
  assign txData   = r.txData;
  assign txLast   = r.txLast;
  assign cmdValid = r.cmdValid;
  assign cmdCode  = r.cmdCode;
  assign cmdMsgId = r.cmdMsgId;
  assign cmdPrio  = r.cmdPrio;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_tciHi;
    ##7 txData == $past(rxTci[15:8], 7);
  endsequence
  sequence s_tciLo;
    ##1 txData == $past(rxTci[7:0], 8);
  endsequence

  AST_TCI_COPY: assert property (rspStart |-> s_tciHi ##0 s_tciLo)
    else $error("response correlation differs from request");
  AST_EVT_TCI: assert property (evtStart |-> ##7 txData == 8'h00 ##1 txData == 8'h00)
    else $error("event correlation not zero");
  AST_DEST: assert property (txValid && txPos7() |-> !txData[opf_pkg::MT_DB])
    else $error("destination flag set");
  AST_RSP_FLAGS: assert property (rspStart |-> ##9 txData[7:5] == 3'b001 && txData[4:0] == $past(code, 9))
    else $error("response flags or code wrong");
  AST_EVT_FLAGS: assert property (txValid && txPos7() && r.txEvt |-> txData[7:5] == 3'b000)
    else $error("event carries ack flags");
  AST_SYNC_INC: assert property (good && incSync |=> r.sync == 8'($past(r.sync) + 1))
    else $error("sync counter not stepped");
  AST_SYNC_HOLD: assert property (!(good && (incSync || code == opf_pkg::TC_MIBRST)) |=> $stable(r.sync))
    else $error("sync counter moved");
  AST_MIB_RST: assert property (good && code == opf_pkg::TC_MIBRST |=> r.sync == 8'h00)
    else $error("sync counter not zeroed");
  AST_ALM_CLR: assert property (good && code == opf_pkg::TC_ALMALL |=> r.almSeq == 16'h0000)
    else $error("alarm counter not cleared");
  AST_NO_ACK: assert property (good && !mt[opf_pkg::MT_AR] && r.txSt == opf_pkg::TX_IDLE |=> !r.txSt)
    else $error("unacked request answered");
  AST_PORT: assert property (rspStart |-> ##3 txData[3:0] == $past(r.portId[11:8], 3) ##1 txData == $past(r.portId[7:0], 4))
    else $error("port identifier wrong");
  AST_LEN: assert property (txLast |-> r.txPos == opf_pkg::LAST_IDX && txValid)
    else $error("packet length wrong");

  function automatic logic txPos7();
    return r.txPos == 6'h07;
  endfunction : txPos7

endmodule : opf_framer

// >>> verilog/opf_pkg.sv
// Constants and types shared by the management packet framer
package opf_pkg;

  // ----------------------------------------------------------------
  // Packet layout (byte indices within the 53-byte packet)
  // ----------------------------------------------------------------
  localparam logic [5:0] HDR_LAST = 6'h0c;  // Last byte held in the header shifter
  localparam logic [5:0] HDR_LEN  = 6'h0d;  // Header bytes: GEM 5 + 2 + 1 + 1 + 4
  localparam logic [5:0] TRL_IDX  = 6'h2d;  // First trailer byte, after 32 content bytes
  localparam logic [5:0] LAST_IDX = 6'h34;  // Final byte of the packet

  // Field positions inside the 104-bit header shifter
  localparam int PORT_MSB = 91;
  localparam int PORT_LSB = 80;
  localparam int PTI_MSB  = 79;
  localparam int PTI_LSB  = 77;
  localparam int TCI_MSB  = 63;
  localparam int TCI_LSB  = 48;
  localparam int MT_MSB   = 47;
  localparam int MT_LSB   = 40;
  localparam int DEV_MSB  = 39;
  localparam int DEV_LSB  = 32;
  localparam int MT_DB    = 7;
  localparam int MT_AR    = 6;
  localparam int MT_AK    = 5;

  // ----------------------------------------------------------------
  // Header and trailer constants for transmitted packets and request checks
  // ----------------------------------------------------------------
  localparam logic [11:0] TX_PLI  = 12'h030;
  localparam logic [2:0]  TX_PTI  = 3'h1;
  localparam logic [2:0]  PTI_MAX = 3'h1;
  localparam logic [12:0] TX_HEC  = 13'h0000;
  localparam logic [15:0] TRL_CPI = 16'h0000;
  localparam logic [15:0] TRL_LEN = 16'h0028;
  localparam logic [15:0] EVT_TCI = 16'h0000;
  localparam logic [7:0]  DEV_ID  = 8'h5c;    // Arbitrary value

  // ----------------------------------------------------------------
  // Type codes
  // ----------------------------------------------------------------
  localparam logic [4:0] TC_MIN    = 5'h04;
  localparam logic [4:0] TC_MAX    = 5'h1c;
  localparam logic [4:0] TC_CREATE = 5'h04;
  localparam logic [4:0] TC_CCONN  = 5'h05;
  localparam logic [4:0] TC_DELETE = 5'h06;
  localparam logic [4:0] TC_DCONN  = 5'h07;
  localparam logic [4:0] TC_SET    = 5'h08;
  localparam logic [4:0] TC_GCONN  = 5'h0a;
  localparam logic [4:0] TC_ALMALL = 5'h0b;
  localparam logic [4:0] TC_ALMNXT = 5'h0c;
  localparam logic [4:0] TC_UPLOAD = 5'h0d;
  localparam logic [4:0] TC_UPLNXT = 5'h0e;
  localparam logic [4:0] TC_MIBRST = 5'h0f;
  localparam logic [4:0] TC_ALARM  = 5'h10;
  localparam logic [4:0] TC_AVC    = 5'h11;
  localparam logic [4:0] TC_SWSTRT = 5'h13;
  localparam logic [4:0] TC_SWEND  = 5'h15;
  localparam logic [4:0] TC_SWACT  = 5'h16;
  localparam logic [4:0] TC_SWCOMM = 5'h17;
  localparam logic [4:0] TC_TESTRS = 5'h1b;

  // ----------------------------------------------------------------
  // Register map and error bits
  // ----------------------------------------------------------------
  localparam logic [3:0] A_CTRL  = 4'h0;
  localparam logic [3:0] A_STAT  = 4'h1;
  localparam logic [3:0] A_ERR   = 4'h2;
  localparam logic [3:0] A_SYNC  = 4'h3;
  localparam logic [3:0] A_ALMSQ = 4'h4;
  localparam logic [3:0] A_UPLSQ = 4'h5;
  localparam logic [3:0] A_EVENT = 4'h6;
  localparam logic [3:0] A_EVTID = 4'h7;
  localparam logic [3:0] A_TCI   = 4'h8;
  localparam int CTRL_EN  = 12;
  localparam int ERR_W    = 9;

  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_HDR = 2'b01, RX_BODY = 2'b11} opf_rx_t;
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} opf_tx_t;

endpackage : opf_pkg
